//--- design/bplc_top.sv
/*
   Burst power loop control: bias search and power loop, modulation lookup,
   comparator slot schedule, quick-trip alarms and transmit disable.
   Assumes an external register port, temperature/supply converter results
   and a comparator result returned for the reference presented.
*/
//
// Overview of operation
// - Compare feedback to 8-bit scaled reference
// - Set point from 36-entry 4 degree table
// - Modulation from 2 degree indexed table
// - Outputs off until supply ok, temperature done
// - Supply alarm enabled needs good supply conversion
// - Ramp bias by startup step until exceeded
// - Binary search, then single LSB integrator
// - Mask quick trips until search done
// - Ceiling during ramp starts binary search
// - Never step past ceiling; try smaller
// - Re-enable reuses known temperature
// - Loop disabled uses manual bias code
// - Disable turns off; release reruns search
// - Soft disable acts like the pin
// - Eight slots, six loop, two alarms
// - Power alarms follow last loop comparison
// - Burst gate edge starts timed sampling
// - Rate code picks delay and period
// - Codes above nine act as nine
// - No alarm updates while gate low
// - Alarms hold until sample shows clear
// - Compare bias to ceiling every update
// - At ceiling set flag; clamp loop bias only
`timescale 1ns/1ps
module bplc_top
#(
   parameter int BIAS_W = 16
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              burst_gate_in,
   input  wire logic              txDisablePin,
   input  wire logic              supply_ok_level,
   input  wire logic              supplyLowAlarmEn,
   input  wire logic              supplyAboveLowAlarm,
   input  wire logic              supplyConvDone,
   input  wire logic              tempConvDone,
   input  wire logic signed [7:0] tempDegC,
   input  wire logic [7:0]        teTableData,
   input  wire logic [7:0]        modTableData,
   input  wire logic [BIAS_W-1:0] startup_increment,
   input  wire logic [BIAS_W-1:0] current_ceiling,
   input  wire logic [7:0]        power_high_threshold,
   input  wire logic [7:0]        power_low_threshold,
   input  wire logic [7:0]        current_high_threshold,
   input  wire logic              compAbove,
   input  wire logic              regWrite,
   input  wire logic [7:0]        regAddr,
   input  wire logic [7:0]        regWrData,
   output logic [7:0]             regRdData,
   output logic [5:0]             teTableIndex,
   output logic [6:0]             modTableIndex,
   output logic [1:0]             compSelect,
   output logic [7:0]             compReference,
   output logic [BIAS_W-1:0]      biasCode,
   output logic [7:0]             modCode,
   output logic                   outputsOn,
   output logic                   power_high_alarm,
   output logic                   power_low_alarm,
   output logic                   current_high_alarm,
   output logic                   ceilingFlag,
   output logic                   searchDone
);
   typedef enum {ST_OFF, ST_WAIT_GATE, ST_RAMP, ST_SEARCH, ST_LOOP} bplc_state_e;
   bplc_state_e state, next_state;

   logic [2:0]        gateSr;
   logic              gateSync;
   logic              sampleStrobe;
   logic [7:0]        rateSelect;
   logic [15:0]       manualBias;
   logic              biasLoopEn;
   logic              softDisable;
   logic              tempKnown;
   logic [7:0]        setPoint;
   logic [2:0]        slot;
   logic              lastAbove;
   logic [BIAS_W-1:0] stepSize;
   logic [BIAS_W-1:0] loopBias, next_loopBias, next_stepSize;
   logic [7:0]        offCnt;
   logic [7:0]        tempOffset;
   logic [2:0]        txSr;
   logic              txSync;
   logic              supplyChecked;

   // Pin synchroniser; only bits 1 and 2 are looked at
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b) gateSr <= 3'h0;
      else        gateSr <= {gateSr[1:0], burst_gate_in};
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)                      gateSync <= 1'b0;
      else if (gateSr[2] == gateSr[1]) gateSync <= gateSr[2];
   end

   // Disable pin is also asynchronous; a few cycles of lag stay well inside the off-time
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b) txSr <= 3'h0;
      else        txSr <= {txSr[1:0], txDisablePin};
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)                  txSync <= 1'b0;
      else if (txSr[2] == txSr[1]) txSync <= txSr[2];
   end

   bplc_sample_timer u_timer
   (
      .clk_sys        (clk_sys),
      .rst_b          (rst_b),
      .gateSync       (gateSync),
      .sampleRateCode (rateSelect[3:0]),
      .sampleStrobe   (sampleStrobe)
   );

   // Register port writes
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         rateSelect <= 8'h00; manualBias <= 16'h0000; biasLoopEn <= 1'b1; softDisable <= 1'b0;
      end
      else if (regWrite)
      begin
         case (regAddr)
            bplc_pkg::REG_SAMPLE_RATE_SELECT: rateSelect <= regWrData;
            bplc_pkg::REG_MANUAL_BIAS_LO:     manualBias[7:0] <= regWrData;
            bplc_pkg::REG_MANUAL_CURRENT_HIGH_ALARM:     manualBias[15:8] <= regWrData;
            bplc_pkg::REG_LOOP_CONTROL:       biasLoopEn <= regWrData[bplc_pkg::BIAS_LOOP_EN_BIT];
            bplc_pkg::REG_SOFT_DISABLE:       softDisable <= regWrData[bplc_pkg::SOFT_DISABLE_BIT];
            default: ;
         endcase
      end
   end

   // Register reads, state visible in the control byte
   always_comb
   begin
      case (regAddr)
         bplc_pkg::REG_SAMPLE_RATE_SELECT: regRdData = rateSelect;
         bplc_pkg::REG_MANUAL_BIAS_LO:     regRdData = manualBias[7:0];
         bplc_pkg::REG_MANUAL_CURRENT_HIGH_ALARM:     regRdData = manualBias[15:8];
         bplc_pkg::REG_LOOP_CONTROL:       regRdData = {5'h00, ceilingFlag, searchDone, biasLoopEn};
         bplc_pkg::REG_SOFT_DISABLE:       regRdData = {1'b0, softDisable, 6'h00};
         default:                          regRdData = 8'h00;
      endcase
   end

   // Table indices from temperature; saturate outside range
   assign tempOffset    = (tempDegC < -8'sd40) ? 8'h00 : 8'(tempDegC + 8'sd40);
   assign teTableIndex  = (tempOffset / 8'd4 > 8'd35) ? 6'd35 : 6'(tempOffset / 8'd4);
   assign modTableIndex = (tempOffset / 8'd2 > 8'd71) ? 7'd71 : 7'(tempOffset / 8'd2);

   // Disable from pin or software
   wire disableReq = txSync | softDisable;
   wire powerReady = supply_ok_level && tempKnown && (!supplyLowAlarmEn || supplyChecked);
   wire loopSlot   = (slot < bplc_pkg::SLOT_POWER);
   wire loopTick   = sampleStrobe && loopSlot;

   // Temperature known after first conversion; kept across disables
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)            tempKnown <= 1'b0;
      else if (tempConvDone) tempKnown <= 1'b1;
   end

   // Last supply conversion verdict; a good level with no conversion does not count
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)              supplyChecked <= 1'b0;
      else if (supplyConvDone) supplyChecked <= supplyAboveLowAlarm;
   end

   // Latch set point and modulation when the outputs come on
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         setPoint <= 8'h00; modCode <= 8'h00;
      end
      else if (state == ST_OFF && next_state != ST_OFF)
      begin
         setPoint <= teTableData;
         modCode  <= modTableData;
      end
      else if (state == ST_OFF)
         modCode <= 8'h00;
   end

   // Comparator slot sequencer
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)            slot <= 3'h0;
      else if (sampleStrobe) slot <= slot + 3'h1;
   end
   assign compSelect    = loopSlot ? 2'd0 : (slot == bplc_pkg::SLOT_POWER) ? 2'd1 : 2'd2;
   assign compReference = loopSlot ? setPoint :
                          (slot == bplc_pkg::SLOT_POWER) ? (lastAbove ? power_high_threshold : power_low_threshold)
                                                          : current_high_threshold;

   // Start-up search and loop
   always_comb
   begin
      next_state    = state;
      next_loopBias = loopBias;
      next_stepSize = stepSize;
      case (state)
         ST_OFF:       if (powerReady && !disableReq) next_state = ST_WAIT_GATE;
         ST_WAIT_GATE: if (gateSync)
                       begin
                          next_loopBias = (startup_increment > current_ceiling) ? current_ceiling : startup_increment;
                          next_state    = ST_RAMP;
                       end
         ST_RAMP:      if (loopTick)
                       begin
                          if (compAbove || loopBias == current_ceiling)
                          begin
                             next_state    = ST_SEARCH;
                             next_stepSize = startup_increment >> 1;
                             if (compAbove) next_loopBias = loopBias - (startup_increment >> 1);
                          end
                          else if (current_ceiling - loopBias < startup_increment)
                             next_loopBias = current_ceiling;
                          else
                             next_loopBias = loopBias + startup_increment;
                       end
         ST_SEARCH:    if (loopTick)
                       begin
                          next_stepSize = stepSize >> 1;
                          if (stepSize <= 1) next_state = ST_LOOP;
                          if (compAbove)
                             next_loopBias = loopBias - (stepSize >> 1);
                          else if (current_ceiling - loopBias >= (stepSize >> 1))
                             next_loopBias = loopBias + (stepSize >> 1);
                       end
         ST_LOOP:      if (loopTick)
                       begin
                          if (compAbove && loopBias != '0)
                             next_loopBias = loopBias - 1'b1;
                          else if (!compAbove && loopBias < current_ceiling)
                             next_loopBias = loopBias + 1'b1;
                       end
         default:      next_state = ST_OFF;
      endcase
      if (disableReq || !supply_ok_level)
      begin
         next_state    = ST_OFF;
         next_loopBias = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         state <= ST_OFF; loopBias <= '0; stepSize <= '0;
      end
      else
      begin
         state <= next_state; loopBias <= next_loopBias; stepSize <= next_stepSize;
      end
   end

   assign outputsOn  = (state != ST_OFF);
   assign searchDone = (state == ST_LOOP);
   // Manual bias bypasses the loop but still honours disable
   assign biasCode = !outputsOn ? '0 : biasLoopEn ? loopBias : BIAS_W'(manualBias);

   // Ceiling flag, checked on every update
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b) ceilingFlag <= 1'b0;
      else        ceilingFlag <= (biasCode >= current_ceiling) && outputsOn;
   end

   // Quick trips: only with gate high and after search; cleared while outputs are off
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !outputsOn)
      begin
         lastAbove <= 1'b0; power_high_alarm <= 1'b0; power_low_alarm <= 1'b0; current_high_alarm <= 1'b0;
      end
      else if (sampleStrobe && gateSync)
      begin
         if (loopSlot) lastAbove <= compAbove;
         else if (searchDone)
         begin
            if (slot == bplc_pkg::SLOT_POWER)
            begin
               power_high_alarm <= lastAbove && compAbove;
               power_low_alarm  <= !lastAbove && !compAbove;
            end
            else
               current_high_alarm <= compAbove;
         end
      end
   end

   // Off-time watch for assertion
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !disableReq) offCnt <= 8'h00;
      else if (offCnt != 8'hFF)  offCnt <= offCnt + 8'h01;
   end

   AST_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
      offCnt >= 8'd2 |-> biasCode == '0 && modCode == 8'h00) else $error("outputs not off");
   AST_CEIL: assert property (@(posedge clk_sys) disable iff (!rst_b)
      biasLoopEn |-> loopBias <= current_ceiling || $changed(current_ceiling)) else $error("bias over ceiling");
   AST_MASK: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !searchDone |=> !$rose(power_high_alarm) && !$rose(current_high_alarm)) else $error("alarm before search");
   AST_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !gateSync && outputsOn && $past(outputsOn) |=> $stable(power_low_alarm)) else $error("alarm moved gate low");
   AST_MAN: assert property (@(posedge clk_sys) disable iff (!rst_b)
      outputsOn && !biasLoopEn |-> biasCode == BIAS_W'(manualBias)) else $error("manual bias ignored");
   AST_INT: assert property (@(posedge clk_sys) disable iff (!rst_b)
      state == ST_LOOP && loopTick && compAbove && loopBias != '0 && !disableReq
      |=> loopBias == $past(loopBias) - 1'b1) else $error("integrator step wrong");
   AST_SOFT: assert property (@(posedge clk_sys) disable iff (!rst_b)
      softDisable |=> state == ST_OFF) else $error("soft disable ignored");
   AST_SLOT: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sampleStrobe && slot == 3'h7 |=> slot == 3'h0) else $error("slot wrap wrong");
endmodule

//--- design/bplc_pkg.sv
/*
   Package for the burst power loop control block: register offsets, field
   positions, table sizes, timing figures and derived cycle counts.
   Assumes a 100 MHz system clock.
*/
package bplc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Register offsets as printed
   localparam logic [7:0] REG_SAMPLE_RATE_SELECT = 8'h88;
   localparam logic [7:0] REG_MANUAL_BIAS_LO     = 8'hF8;
   localparam logic [7:0] REG_MANUAL_CURRENT_HIGH_ALARM     = 8'hF9;
   localparam logic [7:0] REG_LOOP_CONTROL       = 8'h80;
   localparam logic [7:0] REG_SOFT_DISABLE       = 8'h6E;
   localparam int BIAS_LOOP_EN_BIT   = 0;
   localparam int SOFT_DISABLE_BIT   = 6;
   localparam logic [3:0] RATE_CODE_MAX = 4'h9;
   // Table geometry
   localparam int TE_ENTRIES       = 36;
   localparam int TE_WINDOW_DEGC   = 4;
   localparam int MOD_ENTRIES      = 72;
   localparam int MOD_WINDOW_DEGC  = 2;
   localparam int TEMP_LOW_DEGC    = -40;
   // Sample timing in ns, code 0 through 9
   localparam int FIRST_NS [10] = '{350, 550, 750, 950, 1350, 1550, 1750, 2150, 2950, 3150};
   localparam int REP_NS   [10] = '{800, 1200, 1600, 2000, 2800, 3200, 3600, 4400, 6000, 6400};
   localparam int SHUTOFF_TIME_NS = 1000;
   localparam int SHUTOFF_CYC     = SHUTOFF_TIME_NS / CLK_PERIOD_NS;
   localparam int SLOTS           = 8;
   localparam logic [2:0] SLOT_POWER = 3'h6;
   localparam logic [2:0] SLOT_CURRENT = 3'h7;
endpackage

//--- design/bplc_sample_timer.sv
/*
   Sample timer: turns the burst gate rising edge into a train of comparator
   sample strikes, first after the first-sample delay, then at the repeat
   period, while the gate stays high.
   Assumes burst gate already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module bplc_sample_timer
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       gateSync,
   input  wire logic [3:0] sampleRateCode,
   output logic            sampleStrobe
);
   logic [9:0] cnt;
   logic       gatePrev;
   logic       running;
   logic [3:0] code;
   logic [9:0] firstCyc;
   logic [9:0] repCyc;
   wire        gateRise = gateSync & ~gatePrev;

   // Codes above nine take the slowest timing
   assign code = (sampleRateCode > bplc_pkg::RATE_CODE_MAX) ? bplc_pkg::RATE_CODE_MAX : sampleRateCode;

   function automatic logic [9:0] toCyc(input int ns);
      toCyc = 10'((ns + bplc_pkg::CLK_PERIOD_NS - 1) / bplc_pkg::CLK_PERIOD_NS);
   endfunction

   // Table lookup of both delays
   always_comb
   begin
      firstCyc = toCyc(bplc_pkg::FIRST_NS[9]);
      repCyc   = toCyc(bplc_pkg::REP_NS[9]);
      for (int i = 0; i < 10; i++)
      begin
         if (code == 4'(i))
         begin
            firstCyc = toCyc(bplc_pkg::FIRST_NS[i]);
            repCyc   = toCyc(bplc_pkg::REP_NS[i]);
         end
      end
   end

   // Count down to each strike; a new rising edge restarts the train
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         cnt <= 10'h000; gatePrev <= 1'b0; running <= 1'b0; sampleStrobe <= 1'b0;
      end
      else
      begin
         gatePrev     <= gateSync;
         sampleStrobe <= 1'b0;
         if (!gateSync)
            running <= 1'b0;
         else if (gateRise)
         begin
            running <= 1'b1;
            cnt     <= firstCyc - 10'h001;
         end
         else if (running)
         begin
            if (cnt == 10'h000)
            begin
               sampleStrobe <= 1'b1;
               cnt          <= repCyc - 10'h001;
            end
            else
               cnt <= cnt - 10'h001;
         end
      end
   end

   // Cycles since the last gate rise, parked at the top so it never wraps
   logic [5:0] sinceRise;
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)                  sinceRise <= 6'h3F;
      else if (gateRise)           sinceRise <= 6'h00;
      else if (sinceRise != 6'h3F) sinceRise <= sinceRise + 6'h01;
   end

   sequence seqFastRise;
      $rose(gateSync) && code == 4'h0;
   endsequence
   sequence seqFirstDue;
      ##36 (sampleStrobe || !gateSync);
   endsequence

   AST_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_b) seqFastRise |-> seqFirstDue)
      else $error("first strike late");
   AST_EARLY: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sampleStrobe && code == 4'h0 |-> sinceRise >= 6'd35) else $error("first strike early");
endmodule

//--- dv/bplc_laser_model.sv
/*
   Stand-in for the laser driver, photodiode and table memories.
   Assumes light tracks the low byte of the bias code and is dark when off.
*/
`timescale 1ns/1ps
module bplc_laser_model
(
   input  wire logic [15:0] biasCode,
   input  wire logic        outputsOn,
   input  wire logic [7:0]  compReference,
   input  wire logic [5:0]  teTableIndex,
   input  wire logic [6:0]  modTableIndex,
   output logic             compAbove,
   output logic [7:0]       teTableData,
   output logic [7:0]       modTableData
);
   logic [7:0] feedback;
   // Saturates past one byte, so a runaway bias still reads as bright
   assign feedback = !outputsOn ? 8'h00 : (|biasCode[15:8] ? 8'hFF : biasCode[7:0]);
   assign compAbove = feedback > compReference;
   // Distinct fill per entry so a wrong index shows
   assign teTableData = 8'h30 + {2'h0, teTableIndex};
   assign modTableData = {1'b1, modTableIndex};
endmodule

//--- dv/bplc_top_bench.sv
/*
   Self-checking bench for the burst power loop control block.
   Assumes the laser model answers the comparator in the same cycle.
*/
`timescale 1ns/1ps
module bplc_top_bench;
   typedef struct {int k; logic [15:0] e;} bplc_note_s;
   logic              clk_sys, rst_b, burst_gate_in, txDisablePin, supply_ok_level;
   logic              supplyLowAlarmEn, supplyAboveLowAlarm, supplyConvDone, tempConvDone;
   logic              compAbove, regWrite, outputsOn, power_high_alarm, power_low_alarm;
   logic              current_high_alarm, ceilingFlag, searchDone;
   logic signed [7:0] tempDegC;
   logic [7:0]        teTableData, modTableData, power_high_threshold, power_low_threshold;
   logic [7:0]        current_high_threshold, regAddr, regWrData, regRdData, compReference, modCode;
   logic [15:0]       startup_increment, current_ceiling, biasCode, manual, measured;
   logic [5:0]        teTableIndex;
   logic [6:0]        modTableIndex;
   logic [1:0]        compSelect;
   logic [31:0]       seed;
   int                n_errors, compares, sp, cnt, t, c;
   bplc_note_s        notes[$];

   // Free-running 100 MHz clock
   initial
   begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end

   bplc_top DUT
   (
      .clk_sys, .rst_b, .burst_gate_in, .txDisablePin, .supply_ok_level, .supplyLowAlarmEn,
      .supplyAboveLowAlarm, .supplyConvDone, .tempConvDone, .tempDegC, .teTableData,
      .modTableData, .startup_increment, .current_ceiling, .power_high_threshold,
      .power_low_threshold, .current_high_threshold, .compAbove, .regWrite, .regAddr,
      .regWrData, .regRdData, .teTableIndex, .modTableIndex, .compSelect, .compReference,
      .biasCode, .modCode, .outputsOn, .power_high_alarm, .power_low_alarm,
      .current_high_alarm, .ceilingFlag, .searchDone
   );

   bplc_laser_model LASER
   (
      .biasCode, .outputsOn, .compReference, .teTableIndex, .modTableIndex, .compAbove,
      .teTableData, .modTableData
   );

   task wrap_up;
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task cmp_val(input logic [15:0] obs, input logic [15:0] exp);
      compares++;
      if (obs !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, obs, exp);
      end
   endtask

   // Inputs move 1 ns after the edge, never on it
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Note an expectation; the watcher judges it at the next edge
   task chk(input int k, input logic [15:0] e);
      notes.push_back('{k, e});
      tick(1);
   endtask

   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1;
      tick(1);
      regWrite = 0;
      // Let an edge pass so a following write never re-raises the strobe at once
      tick(1);
   endtask

   // Bounded wait for a comparator slot kind to appear
   task wait_sel(input logic [1:0] s);
      cnt = 0;
      while (compSelect !== s && cnt < 9000)
      begin
         tick(1);
         cnt++;
      end
   endtask

   task run_search;
      cnt = 0;
      while (searchDone !== 1'b1 && cnt < 20000)
      begin
         tick(1);
         cnt++;
      end
   endtask

   task check_near;
      tick(700);
      measured = (biasCode + 2 >= sp && biasCode <= sp + 2);
   endtask

   // Watcher: takes the oldest note and compares the named output
   always @(posedge clk_sys)
   begin
      bplc_note_s n;
      if (notes.size() != 0)
      begin
         n = notes.pop_front();
         case (n.k)
            0: cmp_val(biasCode, n.e);
            1: cmp_val({8'h00, modCode}, n.e);
            2: cmp_val({15'h0000, outputsOn}, n.e);
            3: cmp_val({15'h0000, ceilingFlag}, n.e);
            5: cmp_val({15'h0000, current_high_alarm}, n.e);
            6: cmp_val({8'h00, regRdData}, n.e);
            7: cmp_val({10'h000, teTableIndex}, n.e);
            8: cmp_val({9'h000, modTableIndex}, n.e);
            default: cmp_val(measured, n.e);
         endcase
      end
   end

   // Watchdog sized well above the longest expected run
   initial
   begin
      #1_000_000;
      n_errors++;
      wrap_up();
   end

   // Main sequence
   initial
   begin
      seed = 32'h6f22_09d4;
      {rst_b, burst_gate_in, txDisablePin, supply_ok_level, supplyConvDone} = 5'h00;
      {supplyLowAlarmEn, supplyAboveLowAlarm, tempConvDone, regWrite} = 4'h0;
      {regAddr, regWrData, power_high_threshold, current_high_threshold} = 32'h0000_0000;
      power_low_threshold = 8'hFF;
      startup_increment = 16'h0010;
      current_ceiling = 16'h00F0;
      t = $unsigned($random(seed)) % 141 - 40;
      tempDegC = t[7:0];
      sp = 16'h0030 + (t + 40) / 4;
      repeat (16) @(posedge clk_sys);
      #1 rst_b = 1;
      chk(0, 16'h0000);
      chk(2, 16'h0000);
      regAddr = 8'h55;
      chk(6, 16'h0000);
      supplyLowAlarmEn = 1;
      supply_ok_level = 1;
      {tempConvDone, supplyConvDone} = 2'h3;
      tick(1);
      {tempConvDone, supplyConvDone} = 2'h0;
      tick(20);
      chk(2, 16'h0000);
      // A good level alone is not enough; a fresh conversion must report it
      supplyAboveLowAlarm = 1;
      tick(4);
      chk(2, 16'h0000);
      supplyConvDone = 1;
      tick(1);
      supplyConvDone = 0;
      tick(4);
      chk(2, 16'h0001);
      chk(1, {9'h001, 7'((t + 40) / 2)});
      chk(7, 16'((t + 40) / 4));
      chk(8, 16'((t + 40) / 2));
      burst_gate_in = 1;
      run_search();
      chk(5, 16'h0000);
      check_near();
      chk(9, 16'h0001);
      measured = power_high_alarm ^ power_low_alarm;
      chk(9, 16'h0001);
      chk(5, 16'h0001);
      current_high_threshold = 8'hFF;
      tick(700);
      chk(5, 16'h0000);
      // Gate goes low first so no strike lands after the threshold moves
      burst_gate_in = 0;
      tick(8);
      current_high_threshold = 8'h00;
      tick(700);
      chk(5, 16'h0000);
      txDisablePin = 1;
      tick(bplc_pkg::SHUTOFF_CYC);
      chk(2, 16'h0000);
      chk(0, 16'h0000);
      txDisablePin = 0;
      tick(8);
      chk(1, {9'h001, 7'((t + 40) / 2)});
      burst_gate_in = 1;
      cnt = 0;
      // Bias sits at one startup step until the first loop sample moves it
      while (biasCode <= 16'h0010 && cnt < 400)
      begin
         tick(1);
         cnt++;
      end
      measured = (cnt >= 30 && cnt <= 215);
      chk(9, 16'h0001);
      run_search();
      check_near();
      chk(9, 16'h0001);
      reg_wr(bplc_pkg::REG_SOFT_DISABLE, 8'h40);
      tick(bplc_pkg::SHUTOFF_CYC);
      chk(2, 16'h0000);
      current_ceiling = 16'h0020;
      reg_wr(bplc_pkg::REG_SOFT_DISABLE, 8'h00);
      run_search();
      tick(700);
      chk(0, 16'h0020);
      chk(3, 16'h0001);
      current_ceiling = 16'h00F0;
      manual = $random(seed);
      reg_wr(bplc_pkg::REG_LOOP_CONTROL, 8'h00);
      reg_wr(bplc_pkg::REG_MANUAL_BIAS_LO, manual[7:0]);
      reg_wr(bplc_pkg::REG_MANUAL_CURRENT_HIGH_ALARM, manual[15:8]);
      tick(2);
      chk(0, manual);
      chk(6, {8'h00, manual[15:8]});
      // Slot 6 to slot 7 spacing is exactly one repeat period
      for (int i = 0; i < 10; i++)
      begin
         c = (i < 5) ? i * 3 : 9 + (i % 7);
         reg_wr(bplc_pkg::REG_SAMPLE_RATE_SELECT, 8'(c));
         chk(6, 16'(c));
         wait_sel(2'h2);
         wait_sel(2'h1);
         wait_sel(2'h2);
         measured = cnt;
         chk(9, 16'(bplc_pkg::REP_NS[c > 9 ? 9 : c] / 10));
      end
      wrap_up();
   end
endmodule
